/* File: design/lcd_input_ports_map.vh */
// Register indices, field positions and reset values for the LCD-shared input ports.
// Assumes a 32-bit AHB-Lite slave, one register per aligned word at byte address index*4.
`ifndef LCD_INPUT_PORTS_MAP_VH
`define LCD_INPUT_PORTS_MAP_VH

// Register indices (byte address is four times the index).
`define IDX_PORT_F_DATA       10'h107
`define IDX_PORT_G_DATA       10'h108
`define IDX_SEG_ENABLE        10'h10d
`define IDX_PORT_F_DIRECTION  10'h187
`define IDX_PORT_G_DIRECTION  10'h188
`define IDX_PORT_F_LATCH      10'h1f0
`define IDX_PORT_G_LATCH      10'h1f1
`define IDX_BIT_OP            10'h1f2

// Reset values.
`define RST_SEG_ENABLE        8'hff
`define RST_DIRECTION         8'hff
`define RST_LATCH             8'h00
`define RST_PIN_OUT           8'h00

// Segment-enable bits that cover the two ports.
`define SE_F_LOW_BIT          3
`define SE_F_HIGH_BIT         4
`define SE_G_LOW_BIT          5
`define SE_G_TOP_BIT          6

// Segment driver numbers that share the port pins.
`define SEG_BASE_F            12
`define SEG_BASE_G            20
`define SEG_G_TOP             28
`define SEG_COUNT             32

// Bit-operation register fields.
`define BITOP_BIT_LSB         0
`define BITOP_BIT_MSB         2
`define BITOP_PORT_BIT        3
`define BITOP_SET_BIT         4

// Bus constants.
`define HTRANS_NONSEQ_BIT     1
`define HRESP_OKAY            1'b0

`endif

/* File: design/pin_sync.v */
// Two-flop synchroniser for the sixteen port pin inputs.
// Assumes the pins are asynchronous to hclk; only the second stage is read outside.
`timescale 1ns/100ps

module pin_sync (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // Asynchronous pin levels
   input  wire [15:0] pin_async,
   // Synchronised levels
   output wire [15:0] pin_sync_out
);

   reg  [15:0] stage1_r;
   reg  [15:0] stage2_r;

   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_bit
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               stage1_r[i] <= 1'b0;
               stage2_r[i] <= 1'b0;
            end else begin
               stage1_r[i] <= pin_async[i];
               stage2_r[i] <= stage1_r[i];
            end
         end
      end
   endgenerate

   assign pin_sync_out = stage2_r;

endmodule // pin_sync

/* File: design/lcd_shared_input_ports.v */
// Two eight-bit digital-input ports whose pins are shared with LCD segment drivers,
// with data, direction and segment-enable registers on an AHB-Lite slave.
// Assumes a single AHB-Lite master, word-aligned accesses and an LCD waveform
// generator that supplies the level of every segment driver on lcd_seg_drive.
// Operation
// - Pins are digital inputs or segment outputs only
// - Power-on reset selects segment function everywhere
// - Segment enable overrides direction bits
// - Port F bit n uses segment 12+n
// - Port G bits 0-6 segments 20-26, bit7 segment 28
// - Direction registers eight bits, reset all ones
// - Data read returns sampled pin levels
// - Data write stores value in output latch
// - Bit-operation writes sample pins, modify, store latch
// - Input pins overwrite latch during read-modify-write
`timescale 1ns/100ps
`include "lcd_input_ports_map.vh"

module lcd_shared_input_ports #(
   // Set to zero for the smaller package that lacks segment driver 28.
   parameter HAS_TOP_SEGMENT = 1
) (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output wire [31:0] hrdata,
   // Segment levels from the LCD waveform generator
   input  wire [31:0] lcd_seg_drive,
   // Port F pins
   input  wire [7:0]  port_f_pin_in,
   output wire [7:0]  port_f_pin_out,
   output wire [7:0]  port_f_pin_oe,
   // Port G pins
   input  wire [7:0]  port_g_pin_in,
   output wire [7:0]  port_g_pin_out,
   output wire [7:0]  port_g_pin_oe,
   // Input buffer enables and full segment-enable value for other ports
   output wire [7:0]  port_f_input_en,
   output wire [7:0]  port_g_input_en,
   output wire [7:0]  lcd_segment_enable
);

   // Address phase capture.
   reg         ap_valid_r;
   reg         ap_write_r;
   reg  [9:0]  ap_idx_r;
   wire        ap_take;

   // Software-visible registers.
   reg  [7:0]  seg_enable_r;
   reg  [7:0]  seg_enable_nxt;
   reg  [7:0]  dir_f_r;
   reg  [7:0]  dir_f_nxt;
   reg  [7:0]  dir_g_r;
   reg  [7:0]  dir_g_nxt;
   reg  [7:0]  latch_f_r;
   reg  [7:0]  latch_f_nxt;
   reg  [7:0]  latch_g_r;
   reg  [7:0]  latch_g_nxt;

   // Read data and pin drive flip-flops.
   reg  [31:0] hrdata_r;
   reg  [7:0]  rd_byte;
   reg  [7:0]  pin_f_out_r;
   reg  [7:0]  pin_f_oe_r;
   reg  [7:0]  pin_g_out_r;
   reg  [7:0]  pin_g_oe_r;

   // Pin sampling and segment selection.
   wire [15:0] pin_s;
   wire [7:0]  pin_f_s;
   wire [7:0]  pin_g_s;
   wire [7:0]  cover_f;
   wire [7:0]  cover_g;
   wire [7:0]  seg_f;
   wire [7:0]  seg_g;

   // Data phase write strobes.
   wire        wr_en;
   wire [7:0]  wr_byte;
   wire        wr_port_f;
   wire        wr_port_g;
   wire        wr_bit_op;
   wire [2:0]  op_bit;
   wire        op_port_g;
   wire        op_set;
   wire [7:0]  op_mask;
   wire [7:0]  op_base;
   wire [7:0]  op_result;

   // The slave never inserts wait states and never reports an error.
   assign hreadyout = 1'b1;
   assign hresp     = `HRESP_OKAY;
   assign hrdata    = hrdata_r;

   // Only transfers that cover byte lane zero of the word are taken.
   assign ap_take = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready & (haddr[1:0] == 2'b00);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_idx_r   <= 10'h000;
      end else if (hready) begin
         ap_valid_r <= ap_take;
         ap_write_r <= hwrite;
         ap_idx_r   <= haddr[11:2];
      end
   end

   pin_sync u_pin_sync (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .pin_async    ({port_g_pin_in, port_f_pin_in}),
      .pin_sync_out (pin_s)
   );

   assign pin_f_s = pin_s[7:0];
   assign pin_g_s = pin_s[15:8];

   // Segment-enable bits 3 to 6 each cover a fixed group of pins.
   assign cover_f = {{4{seg_enable_r[`SE_F_HIGH_BIT]}},
                     {4{seg_enable_r[`SE_F_LOW_BIT]}}};
   assign cover_g = {seg_enable_r[`SE_G_TOP_BIT],
                     {7{seg_enable_r[`SE_G_LOW_BIT]}}};

   // Pick the segment driver that shares each pin.
   genvar n;
   generate
      for (n = 0; n < 8; n = n + 1) begin : g_seg_map
         assign seg_f[n] = lcd_seg_drive[`SEG_BASE_F + n];
         if (n < 7) begin : g_low
            assign seg_g[n] = lcd_seg_drive[`SEG_BASE_G + n];
         end else begin : g_top
            assign seg_g[n] = lcd_seg_drive[`SEG_G_TOP];
         end
      end
   endgenerate

   // Data phase decode.
   assign wr_en     = ap_valid_r & ap_write_r;
   assign wr_byte   = hwdata[7:0];
   assign wr_port_f = wr_en & (ap_idx_r == `IDX_PORT_F_DATA);
   assign wr_port_g = wr_en & (ap_idx_r == `IDX_PORT_G_DATA);
   assign wr_bit_op = wr_en & (ap_idx_r == `IDX_BIT_OP);

   // A bit operation reads the pins of the chosen port, changes one bit and
   // writes all eight bits back, so input pins replace their latch bits.
   assign op_bit    = hwdata[`BITOP_BIT_MSB:`BITOP_BIT_LSB];
   assign op_port_g = hwdata[`BITOP_PORT_BIT];
   assign op_set    = hwdata[`BITOP_SET_BIT];
   assign op_mask   = 8'h01 << op_bit;
   assign op_base   = op_port_g ? pin_g_s : pin_f_s;
   assign op_result = op_set ? (op_base | op_mask) : (op_base & ~op_mask);

   always @* begin
      seg_enable_nxt = seg_enable_r;
      dir_f_nxt      = dir_f_r;
      dir_g_nxt      = dir_g_r;
      latch_f_nxt    = latch_f_r;
      latch_g_nxt    = latch_g_r;
      if (wr_en) begin
         case (ap_idx_r)
            `IDX_SEG_ENABLE: begin
               seg_enable_nxt = wr_byte;
            end
            `IDX_PORT_F_DIRECTION: begin
               dir_f_nxt = wr_byte;
            end
            `IDX_PORT_G_DIRECTION: begin
               dir_g_nxt = wr_byte;
            end
            default: begin
               seg_enable_nxt = seg_enable_r;
            end
         endcase
      end
      if (wr_port_f) begin
         latch_f_nxt = wr_byte;
      end
      if (wr_port_g) begin
         latch_g_nxt = wr_byte;
      end
      if (wr_bit_op && !op_port_g) begin
         latch_f_nxt = op_result;
      end
      if (wr_bit_op && op_port_g) begin
         latch_g_nxt = op_result;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seg_enable_r <= `RST_SEG_ENABLE;
         dir_f_r      <= `RST_DIRECTION;
         dir_g_r      <= `RST_DIRECTION;
         latch_f_r    <= `RST_LATCH;
         latch_g_r    <= `RST_LATCH;
      end else begin
         seg_enable_r <= seg_enable_nxt;
         dir_f_r      <= dir_f_nxt;
         dir_g_r      <= dir_g_nxt;
         latch_f_r    <= latch_f_nxt;
         latch_g_r    <= latch_g_nxt;
      end
   end

   // Read data is chosen in the address phase; register values are taken from
   // their next values so a read right behind a write sees the new contents.
   always @* begin
      rd_byte = 8'h00;
      case (haddr[11:2])
         `IDX_PORT_F_DATA: begin
            rd_byte = pin_f_s;
         end
         `IDX_PORT_G_DATA: begin
            rd_byte = pin_g_s;
         end
         `IDX_SEG_ENABLE: begin
            rd_byte = seg_enable_nxt;
         end
         `IDX_PORT_F_DIRECTION: begin
            rd_byte = dir_f_nxt;
         end
         `IDX_PORT_G_DIRECTION: begin
            rd_byte = dir_g_nxt;
         end
         `IDX_PORT_F_LATCH: begin
            rd_byte = latch_f_nxt;
         end
         `IDX_PORT_G_LATCH: begin
            rd_byte = latch_g_nxt;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (hready) begin
         if (ap_take && !hwrite) begin
            hrdata_r <= {24'h00_0000, rd_byte};
         end else begin
            hrdata_r <= 32'h0000_0000;
         end
      end
   end

   // Pin drive: a pin is driven only by its segment driver while its group is
   // enabled; the direction bits and the latch never reach the pin.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_f_oe_r  <= 8'hff;
         pin_g_oe_r  <= {(HAS_TOP_SEGMENT != 0), 7'h7f};
         pin_f_out_r <= `RST_PIN_OUT;
         pin_g_out_r <= `RST_PIN_OUT;
      end else begin
         pin_f_oe_r  <= cover_f;
         pin_g_oe_r  <= {cover_g[7] & (HAS_TOP_SEGMENT != 0), cover_g[6:0]};
         pin_f_out_r <= seg_f & cover_f;
         pin_g_out_r <= seg_g & {cover_g[7] & (HAS_TOP_SEGMENT != 0), cover_g[6:0]};
      end
   end

   assign port_f_pin_out = pin_f_out_r;
   assign port_f_pin_oe  = pin_f_oe_r;
   assign port_g_pin_out = pin_g_out_r;
   assign port_g_pin_oe  = pin_g_oe_r;

   // A pin's digital input buffer only opens once its group is cleared.
   assign port_f_input_en = ~cover_f;
   assign port_g_input_en = ~cover_g;

   assign lcd_segment_enable = seg_enable_r;

endmodule // lcd_shared_input_ports

/* File: bench/lcd_ports_chk.sv */
// Checker for the LCD-shared input ports, watching the top module's ports only.
// Assumes one clock hclk and the active-low asynchronous reset hresetn.
`timescale 1ns/100ps

module lcd_ports_chk #(
   parameter HAS_TOP_SEGMENT = 1
) (
   // Clock, reset and bus
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   // Segment levels and pins
   input wire [31:0] lcd_seg_drive,
   input wire [7:0]  port_f_pin_out,
   input wire [7:0]  port_f_pin_oe,
   input wire [7:0]  port_g_pin_out,
   input wire [7:0]  port_g_pin_oe,
   input wire [7:0]  port_f_input_en,
   input wire [7:0]  port_g_input_en,
   input wire [7:0]  lcd_segment_enable
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_f_low_cover: assert property ($past(hresetn) |->
      port_f_pin_oe[3:0] == {4{$past(lcd_segment_enable[3])}}) else $error("f low oe wrong");
   a_f_high_cover: assert property ($past(hresetn) |->
      port_f_pin_oe[7:4] == {4{$past(lcd_segment_enable[4])}}) else $error("f high oe wrong");
   a_g_cover: assert property ($past(hresetn) |-> port_g_pin_oe ==
      {$past(lcd_segment_enable[6]) & (HAS_TOP_SEGMENT != 0), {7{$past(lcd_segment_enable[5])}}})
      else $error("g oe wrong");
   a_f_seg_map: assert property ($past(hresetn) |->
      port_f_pin_out == ($past(lcd_seg_drive[19:12]) & port_f_pin_oe)) else $error("f seg wrong");
   a_g_seg_map: assert property ($past(hresetn) |-> port_g_pin_out ==
      ({$past(lcd_seg_drive[28]), $past(lcd_seg_drive[26:20])} & port_g_pin_oe))
      else $error("g seg wrong");
   a_input_select: assert property (
      port_f_input_en == ~{{4{lcd_segment_enable[4]}}, {4{lcd_segment_enable[3]}}} &&
      port_g_input_en[6:0] == ~{7{lcd_segment_enable[5]}}) else $error("input enable wrong");
   a_no_drive_input: assert property ($past(hresetn) |->
      (port_f_pin_oe & $past(port_f_input_en)) == 8'h00 &&
      (port_g_pin_oe & $past(port_g_input_en)) == 8'h00) else $error("input pin driven");
   a_rdata_quiet: assert property ($past(hresetn) &&
      !$past(hsel && htrans[1] && !hwrite && hready) |-> hrdata == 32'h0)
      else $error("read data outside data phase");
   a_reset_segment: assert property ($rose(hresetn) |->
      lcd_segment_enable == 8'hff && port_f_pin_oe == 8'hff && hresp == 1'b0 && hreadyout)
      else $error("reset state wrong");
endmodule // lcd_ports_chk

/* File: bench/pin_partner.sv */
// Model of the board side of the sixteen shared pins.
// Assumes the device drives a pin only while its enable is high.
`timescale 1ns/100ps

module pin_partner (
   // Device side
   input  wire [7:0] f_oe,
   input  wire [7:0] f_out,
   input  wire [7:0] g_oe,
   input  wire [7:0] g_out,
   // External sources and resolved levels
   input  wire [7:0] f_ext,
   input  wire [7:0] g_ext,
   output wire [7:0] f_level,
   output wire [7:0] g_level
);
   // A segment pin shows the driver level, an input pin the external source.
   assign f_level = (f_oe & f_out) | (~f_oe & f_ext);
   assign g_level = (g_oe & g_out) | (~g_oe & g_ext);
endmodule // pin_partner

/* File: bench/testbench.sv */
// Self-checking bench for the LCD-shared input ports over AHB-Lite.
// Assumes the checker and pin model files are compiled before this one.
`timescale 1ns/100ps

module testbench;
   reg         hclk, hresetn, hsel, hwrite;
   reg  [11:0] haddr;
   reg  [1:0]  htrans;
   reg  [2:0]  hsize;
   reg  [31:0] hwdata, seg_drive, rd;
   reg  [7:0]  f_ext, g_ext, s;
   wire        hreadyout, hresp;
   wire [31:0] hrdata;
   wire [7:0]  f_out, f_oe, g_out, g_oe, f_ien, g_ien, seg_en, f_lvl, g_lvl;
   wire [7:0]  g_out_sm, g_oe_sm;
   integer     failures, checks, cycles, i;

   lcd_shared_input_ports u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lcd_seg_drive(seg_drive),
      .port_f_pin_in(f_lvl), .port_f_pin_out(f_out), .port_f_pin_oe(f_oe),
      .port_g_pin_in(g_lvl), .port_g_pin_out(g_out), .port_g_pin_oe(g_oe),
      .port_f_input_en(f_ien), .port_g_input_en(g_ien), .lcd_segment_enable(seg_en));
   pin_partner u_pins (.f_oe(f_oe), .f_out(f_out), .g_oe(g_oe), .g_out(g_out),
      .f_ext(f_ext), .g_ext(g_ext), .f_level(f_lvl), .g_level(g_lvl));
   // Small-package variant without segment driver 28, fed by the same bus and pins.
   lcd_shared_input_ports #(.HAS_TOP_SEGMENT(0)) u_dut_small (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(),
      .lcd_seg_drive(seg_drive), .port_f_pin_in(f_lvl), .port_f_pin_out(),
      .port_f_pin_oe(), .port_g_pin_in(g_lvl), .port_g_pin_out(g_out_sm),
      .port_g_pin_oe(g_oe_sm), .port_f_input_en(), .port_g_input_en(),
      .lcd_segment_enable());

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   task tally_and_finish;
      begin
         $display("failures %0d checks %0d", failures, checks);
         if (failures == 0 && checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask

   always @(posedge hclk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         failures = failures + 1;
         tally_and_finish;
      end
   end

   task chk(input string n, input [31:0] e, input [31:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         end
      end
   endtask

   // One single transfer; read data lands in rd at the edge ending the data phase.
   task rw(input [11:0] a, input w, input [7:0] d);
      begin
         @(posedge hclk);
         hsel <= 1'b1;
         haddr <= a;
         hwrite <= w;
         htrans <= 2'b10;
         @(posedge hclk);
         while (!hreadyout) @(posedge hclk);
         htrans <= 2'b00;
         hwdata <= {24'h0, d};
         @(posedge hclk);
         while (!hreadyout) @(posedge hclk);
         rd = hrdata;
      end
   endtask

   task rdchk(input string n, input [11:0] a, input [7:0] e);
      begin
         rw(a, 1'b0, 8'h00);
         chk(n, {24'h0, e}, rd);
      end
   endtask

   task settle;
      begin
         repeat (4) @(posedge hclk);
         #1;
      end
   endtask

   task t_reset;
      begin
         chk("oe f", 32'hff, f_oe);
         chk("oe g", 32'hff, g_oe);
         chk("oe g small", 32'h7f, g_oe_sm);
         chk("input en", 32'h0, {f_ien, g_ien});
         rdchk("seg enable", 12'h434, 8'hff);
         rdchk("dir f", 12'h61c, 8'hff);
         rdchk("dir g", 12'h620, 8'hff);
         rdchk("data f", 12'h41c, 8'h00);
         rdchk("unmapped", 12'h7fc, 8'h00);
      end
   endtask

   task t_groups;
      begin
         rw(12'h61c, 1'b1, 8'h00);
         rw(12'h620, 1'b1, 8'h00);
         rdchk("dir f", 12'h61c, 8'h00);
         rdchk("dir g", 12'h620, 8'h00);
         for (i = 3; i < 7; i = i + 1) begin
            s = ~(8'h01 << i);
            rw(12'h434, 1'b1, s);
            settle;
            rdchk("seg enable", 12'h434, s);
            chk("oe f", {{4{s[4]}}, {4{s[3]}}}, f_oe);
            chk("oe g", {s[6], {7{s[5]}}}, g_oe);
            chk("input en", {16'h0, ~{{4{s[4]}}, {4{s[3]}}, s[6], {7{s[5]}}}},
               {f_ien, g_ien});
         end
      end
   endtask

   task t_segmap;
      begin
         rw(12'h434, 1'b1, 8'hff);
         for (i = 0; i < 2; i = i + 1) begin
            @(posedge hclk);
            seg_drive <= i ? 32'hea3c5691 : 32'h15c3a96e;
            settle;
            chk("seg f", seg_drive[19:12], f_out);
            chk("seg g", {seg_drive[28], seg_drive[26:20]}, g_out);
            chk("seg g small", {1'b0, seg_drive[26:20]}, g_out_sm);
         end
      end
   endtask

   task t_pins;
      begin
         rw(12'h434, 1'b1, 8'h00);
         @(posedge hclk);
         f_ext <= 8'ha5;
         g_ext <= 8'h3c;
         settle;
         chk("oe off", 32'h0, {f_oe, g_oe, f_out, g_out});
         rdchk("data f", 12'h41c, 8'ha5);
         rdchk("data g", 12'h420, 8'h3c);
      end
   endtask

   task t_rmw;
      begin
         rw(12'h41c, 1'b1, 8'h5a);
         rdchk("latch f", 12'h7c0, 8'h5a);
         rdchk("data f", 12'h41c, 8'ha5);
         rw(12'h7c8, 1'b1, 8'h07);
         rdchk("latch f", 12'h7c0, 8'h25);
         rw(12'h420, 1'b1, 8'h81);
         rw(12'h7c8, 1'b1, 8'h18);
         rdchk("latch g", 12'h7c4, 8'h3d);
         rw(12'h7c0, 1'b1, 8'hff);
         rdchk("latch f", 12'h7c0, 8'h25);
      end
   endtask

   // A second reset in mid-run must restore segment function and register defaults.
   task t_rerun;
      begin
         @(posedge hclk);
         hresetn <= 1'b0;
         repeat (3) @(posedge hclk);
         hresetn <= 1'b1;
         #1;
         chk("oe f", 32'hff, f_oe);
         chk("oe g small", 32'h7f, g_oe_sm);
         rdchk("seg enable", 12'h434, 8'hff);
         rdchk("dir g", 12'h620, 8'hff);
         rdchk("latch f", 12'h7c0, 8'h00);
      end
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 12'h000;
      htrans = 2'b00;
      hsize = 3'b010;
      hwdata = 32'h0;
      seg_drive = 32'h0;
      f_ext = 8'h00;
      g_ext = 8'h00;
      failures = 0;
      checks = 0;
      cycles = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      t_reset;
      t_groups;
      t_segmap;
      t_pins;
      t_rmw;
      t_rerun;
      tally_and_finish;
   end
endmodule // testbench

bind lcd_shared_input_ports lcd_ports_chk #(.HAS_TOP_SEGMENT(HAS_TOP_SEGMENT)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .lcd_seg_drive(lcd_seg_drive), .port_f_pin_out(port_f_pin_out),
   .port_f_pin_oe(port_f_pin_oe), .port_g_pin_out(port_g_pin_out),
   .port_g_pin_oe(port_g_pin_oe), .port_f_input_en(port_f_input_en),
   .port_g_input_en(port_g_input_en), .lcd_segment_enable(lcd_segment_enable));
